// ===== logic/lvd_ctrl.sv
// Supply drop detector control, flag and interrupt logic with APB registers
//
// Overview of operation
// - Enabled comparator reporting supply at trip point sets the detector flag.
// - Four-bit writable level field in control bits 3:0 selects sixteen trip codes.
// - Level code all ones routes comparator input from external trip input.
// - Control bit 4 powers the comparator and divider on or off.
// - No detector interrupt while the reference stable bit is clear.
// - Flag held off for a fixed settling interval after enabling the reference.
// - Detector runs during sleep; a crossing sets the flag and wakes the device.
// - Wake goes to the interrupt vector only when interrupts are globally enabled.
// - Any reset returns all detector registers to reset, detector off.
// - Stable bit reads one when the level can be flagged, zero otherwise.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module lvd_ctrl (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic [31:0] PRDATA,
  output var  logic        PREADY,
  output var  logic        PSLVERR,
  input  wire logic        COMPARATOR_TRIP,
  input  wire logic        SLEEP_ACTIVE,
  output var  logic        DETECTOR_POWER_EN,
  output var  logic        EXTERNAL_TRIP_SELECT,
  output var  logic [3:0]  TRIP_LEVEL,
  output var  logic        IRQ,
  output var  logic        WAKE
);

  logic [3:0] trip_level_field_q;
  logic       detector_power_enable_q;
  logic       global_irq_enable_q;
  logic [6:0] core_irq_other_q;
  logic       detector_irq_priority_q;
  logic       detector_flag_q;
  logic       detector_flag_d;
  logic       detector_irq_enable_q;
  logic       reference_stable_status;
  logic       apb_setup;
  logic       apb_commit;
  logic       wr_commit;
  logic       addr_hit;
  logic [7:0] rd_byte;
  logic       trip_event;

  assign apb_setup  = PSEL && !PENABLE;
  assign apb_commit = PSEL && PENABLE && PREADY;
  assign wr_commit  = apb_commit && PWRITE && addr_hit;

  settle_timer u_settle (
    .clk    (CORE_CLK),
    .rst    (RST),
    .enable (detector_power_enable_q),
    .stable (reference_stable_status)
  );

  always_comb begin
    addr_hit = 1'b1;
    rd_byte  = 8'h00;
    unique case (PADDR)
      lvd_pkg::DETECTOR_CONTROL_OFS:
        rd_byte = {2'b00, reference_stable_status, detector_power_enable_q,
                   trip_level_field_q};
      lvd_pkg::CORE_INTERRUPT_CONTROL_OFS:
        rd_byte = {global_irq_enable_q, core_irq_other_q};
      lvd_pkg::PERIPHERAL_PRIORITY_TWO_OFS:
        rd_byte = {5'b00000, detector_irq_priority_q, 2'b00};
      lvd_pkg::PERIPHERAL_FLAGS_TWO_OFS:
        rd_byte = {5'b00000, detector_flag_q, 2'b00};
      lvd_pkg::PERIPHERAL_ENABLES_TWO_OFS:
        rd_byte = {5'b00000, detector_irq_enable_q, 2'b00};
      default:
        addr_hit = 1'b0;
    endcase
  end

  // Bus answer: one wait-free access phase, data registered at setup
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= lvd_pkg::ZERO_WORD;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= apb_setup;
      PSLVERR <= apb_setup && !addr_hit;
      if (apb_setup && !PWRITE) begin
        PRDATA <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Detector control; the stable bit is never written
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      trip_level_field_q      <= lvd_pkg::DETECTOR_CONTROL_RST[3:0];
      detector_power_enable_q <= lvd_pkg::DETECTOR_CONTROL_RST[4];
    end else if (wr_commit && PADDR == lvd_pkg::DETECTOR_CONTROL_OFS) begin
      trip_level_field_q      <= PWDATA[lvd_pkg::TRIP_LEVEL_LSB +: lvd_pkg::TRIP_LEVEL_W];
      detector_power_enable_q <= PWDATA[lvd_pkg::POWER_ENABLE_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      global_irq_enable_q <= lvd_pkg::CORE_INTERRUPT_RST[7];
      core_irq_other_q    <= lvd_pkg::CORE_INTERRUPT_RST[6:0];
    end else if (wr_commit && PADDR == lvd_pkg::CORE_INTERRUPT_CONTROL_OFS) begin
      global_irq_enable_q <= PWDATA[lvd_pkg::GLOBAL_IRQ_BIT];
      core_irq_other_q    <= PWDATA[6:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      detector_irq_priority_q <= lvd_pkg::PRIORITY_TWO_RST[2];
      detector_irq_enable_q   <= lvd_pkg::ENABLES_TWO_RST[2];
    end else if (wr_commit) begin
      if (PADDR == lvd_pkg::PERIPHERAL_PRIORITY_TWO_OFS) begin
        detector_irq_priority_q <= PWDATA[lvd_pkg::DETECTOR_FLAG_BIT];
      end
      if (PADDR == lvd_pkg::PERIPHERAL_ENABLES_TWO_OFS) begin
        detector_irq_enable_q <= PWDATA[lvd_pkg::DETECTOR_FLAG_BIT];
      end
    end
  end

  // Comparator result only counts once the reference has settled
  assign trip_event = detector_power_enable_q && reference_stable_status
                      && COMPARATOR_TRIP;

  // Sticky flag, write one to clear; a trip in the clear cycle still wins
  always_comb begin
    detector_flag_d = detector_flag_q;
    if (wr_commit && PADDR == lvd_pkg::PERIPHERAL_FLAGS_TWO_OFS
        && PWDATA[lvd_pkg::DETECTOR_FLAG_BIT]) begin
      detector_flag_d = 1'b0;
    end
    if (trip_event) begin
      detector_flag_d = 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      detector_flag_q <= lvd_pkg::FLAGS_TWO_RST[2];
    end else begin
      detector_flag_q <= detector_flag_d;
    end
  end

  // Pin-facing outputs and the interrupt and wake levels
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      DETECTOR_POWER_EN    <= 1'b0;
      EXTERNAL_TRIP_SELECT <= 1'b0;
      TRIP_LEVEL           <= 4'h0;
      IRQ                  <= 1'b0;
      WAKE                 <= 1'b0;
    end else begin
      DETECTOR_POWER_EN    <= detector_power_enable_q;
      EXTERNAL_TRIP_SELECT <= trip_level_field_q == lvd_pkg::EXTERNAL_LEVEL_CODE;
      TRIP_LEVEL           <= trip_level_field_q;
      // Vectoring needs the global enable; wake alone does not
      IRQ  <= detector_flag_q && detector_irq_enable_q && global_irq_enable_q
              && reference_stable_status;
      WAKE <= SLEEP_ACTIVE && detector_flag_q;
    end
  end

  a_trip_sets_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
    trip_event |=> detector_flag_q)
    else $error("trip did not set detector flag");

  a_flag_needs_stable: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(detector_flag_q) |-> $past(reference_stable_status) && $past(COMPARATOR_TRIP))
    else $error("flag set without settled reference");

  a_level_pins: assert property (@(posedge CORE_CLK) disable iff (RST)
    ##1 TRIP_LEVEL == $past(trip_level_field_q))
    else $error("trip level output wrong");

  a_ext_select: assert property (@(posedge CORE_CLK) disable iff (RST)
    ##1 EXTERNAL_TRIP_SELECT == ($past(trip_level_field_q) == lvd_pkg::EXTERNAL_LEVEL_CODE))
    else $error("external input select wrong");

  a_power_pin: assert property (@(posedge CORE_CLK) disable iff (RST)
    ##1 DETECTOR_POWER_EN == $past(detector_power_enable_q))
    else $error("power enable output wrong");

  a_irq_stable: assert property (@(posedge CORE_CLK) disable iff (RST)
    IRQ |-> $past(reference_stable_status) && $past(global_irq_enable_q))
    else $error("interrupt without stable reference or global enable");

  a_irq_raise: assert property (@(posedge CORE_CLK) disable iff (RST)
    detector_flag_q && detector_irq_enable_q && global_irq_enable_q
      && reference_stable_status |=> IRQ)
    else $error("interrupt not raised");

  a_wake_sleep: assert property (@(posedge CORE_CLK) disable iff (RST)
    SLEEP_ACTIVE && trip_event ##1 SLEEP_ACTIVE |=> WAKE)
    else $error("no wake on trip in sleep");

  a_stable_clears: assert property (@(posedge CORE_CLK) disable iff (RST)
    !detector_power_enable_q |=> !reference_stable_status)
    else $error("stable bit stayed set while disabled");

  a_settle_time: assert property (@(posedge CORE_CLK) disable iff (RST)
    $rose(reference_stable_status) |->
      $past(detector_power_enable_q, lvd_pkg::SETTLE_CYCLES)
      && !$past(detector_power_enable_q, lvd_pkg::SETTLE_CYCLES + 1))
    else $error("settling interval wrong length");

  a_stable_read: assert property (@(posedge CORE_CLK) disable iff (RST)
    apb_setup && !PWRITE && PADDR == lvd_pkg::DETECTOR_CONTROL_OFS |=>
      PRDATA[lvd_pkg::REF_STABLE_BIT] == $past(reference_stable_status))
    else $error("stable bit read wrong");

  // Write and read-back paths of the register fields
  a_level_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_commit && PADDR == lvd_pkg::DETECTOR_CONTROL_OFS |=>
      trip_level_field_q == $past(PWDATA[lvd_pkg::TRIP_LEVEL_LSB +: lvd_pkg::TRIP_LEVEL_W]))
    else $error("level field write lost");

  a_level_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    !(wr_commit && PADDR == lvd_pkg::DETECTOR_CONTROL_OFS) |=>
      $stable(trip_level_field_q))
    else $error("level field changed without a write");

  a_enable_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_commit && PADDR == lvd_pkg::DETECTOR_CONTROL_OFS |=>
      detector_power_enable_q == $past(PWDATA[lvd_pkg::POWER_ENABLE_BIT]))
    else $error("power enable write lost");

  a_global_write: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_commit && PADDR == lvd_pkg::CORE_INTERRUPT_CONTROL_OFS |=>
      global_irq_enable_q == $past(PWDATA[lvd_pkg::GLOBAL_IRQ_BIT]))
    else $error("global enable write lost");

  a_level_read: assert property (@(posedge CORE_CLK) disable iff (RST)
    apb_setup && !PWRITE && PADDR == lvd_pkg::DETECTOR_CONTROL_OFS |=>
      PRDATA[lvd_pkg::TRIP_LEVEL_LSB +: lvd_pkg::TRIP_LEVEL_W] == $past(trip_level_field_q))
    else $error("level field read wrong");

  a_enable_read: assert property (@(posedge CORE_CLK) disable iff (RST)
    apb_setup && !PWRITE && PADDR == lvd_pkg::DETECTOR_CONTROL_OFS |=>
      PRDATA[lvd_pkg::POWER_ENABLE_BIT] == $past(detector_power_enable_q))
    else $error("power enable read wrong");

  a_flag_read: assert property (@(posedge CORE_CLK) disable iff (RST)
    apb_setup && !PWRITE && PADDR == lvd_pkg::PERIPHERAL_FLAGS_TWO_OFS |=>
      PRDATA[lvd_pkg::DETECTOR_FLAG_BIT] == $past(detector_flag_q))
    else $error("detector flag read wrong");

  // Sticky flag, stable bit, interrupt and wake levels
  a_flag_holds: assert property (@(posedge CORE_CLK) disable iff (RST)
    detector_flag_q && !(wr_commit && PADDR == lvd_pkg::PERIPHERAL_FLAGS_TWO_OFS
      && PWDATA[lvd_pkg::DETECTOR_FLAG_BIT]) |=> detector_flag_q)
    else $error("detector flag lost without a clear");

  a_flag_clear: assert property (@(posedge CORE_CLK) disable iff (RST)
    wr_commit && PADDR == lvd_pkg::PERIPHERAL_FLAGS_TWO_OFS
      && PWDATA[lvd_pkg::DETECTOR_FLAG_BIT] && !trip_event |=> !detector_flag_q)
    else $error("detector flag not cleared");

  a_flag_only_trip: assert property (@(posedge CORE_CLK) disable iff (RST)
    !detector_flag_q && !trip_event |=> !detector_flag_q)
    else $error("detector flag set without a trip");

  a_flag_off_disabled: assert property (@(posedge CORE_CLK) disable iff (RST)
    !detector_power_enable_q && !detector_flag_q |=> !detector_flag_q)
    else $error("detector flag set while powered down");

  a_stable_kept: assert property (@(posedge CORE_CLK) disable iff (RST)
    detector_power_enable_q && reference_stable_status |=> reference_stable_status)
    else $error("stable bit dropped while enabled");

  a_irq_needs_flag: assert property (@(posedge CORE_CLK) disable iff (RST)
    IRQ |-> $past(detector_flag_q) && $past(detector_irq_enable_q))
    else $error("interrupt without flag or enable");

  a_irq_drop: assert property (@(posedge CORE_CLK) disable iff (RST)
    !reference_stable_status |=> !IRQ)
    else $error("interrupt while reference unsettled");

  a_wake_needs_sleep: assert property (@(posedge CORE_CLK) disable iff (RST)
    WAKE |-> $past(SLEEP_ACTIVE) && $past(detector_flag_q))
    else $error("wake without sleep and flag");

  a_wake_level: assert property (@(posedge CORE_CLK) disable iff (RST)
    SLEEP_ACTIVE && detector_flag_q |=> WAKE)
    else $error("wake missing while flag set in sleep");

  // No disable here, so the reset cycles themselves are watched
  a_reset_off: assert property (@(posedge CORE_CLK)
    RST |=> !DETECTOR_POWER_EN && !IRQ && !WAKE && !detector_power_enable_q
      && !EXTERNAL_TRIP_SELECT)
    else $error("detector not off after reset");

  a_reset_regs: assert property (@(posedge CORE_CLK)
    RST |=> trip_level_field_q == lvd_pkg::DETECTOR_CONTROL_RST[3:0]
      && detector_flag_q == lvd_pkg::FLAGS_TWO_RST[2] && !reference_stable_status)
    else $error("detector registers not reset");

endmodule // lvd_ctrl
`default_nettype wire

// ===== logic/lvd_pkg.sv
// Constants for the supply drop detector control block
package lvd_pkg;

  // Register byte offsets on the APB bus
  localparam logic [7:0] DETECTOR_CONTROL_OFS       = 8'h00;
  localparam logic [7:0] CORE_INTERRUPT_CONTROL_OFS = 8'h04;
  localparam logic [7:0] PERIPHERAL_PRIORITY_TWO_OFS = 8'h08;
  localparam logic [7:0] PERIPHERAL_FLAGS_TWO_OFS   = 8'h0C;
  localparam logic [7:0] PERIPHERAL_ENABLES_TWO_OFS = 8'h10;

  // Field positions
  localparam int TRIP_LEVEL_LSB     = 0;
  localparam int TRIP_LEVEL_W       = 4;
  localparam int POWER_ENABLE_BIT   = 4;
  localparam int REF_STABLE_BIT     = 5;
  localparam int GLOBAL_IRQ_BIT     = 7;
  localparam int DETECTOR_FLAG_BIT  = 2;

  // Reset values
  localparam logic [7:0] DETECTOR_CONTROL_RST = 8'h00;
  localparam logic [7:0] CORE_INTERRUPT_RST   = 8'h00;
  localparam logic [7:0] PRIORITY_TWO_RST     = 8'h00;
  localparam logic [7:0] FLAGS_TWO_RST        = 8'h00;
  localparam logic [7:0] ENABLES_TWO_RST      = 8'h00;

  // Level code that selects the external trip input
  localparam logic [3:0] EXTERNAL_LEVEL_CODE = 4'hF;

  // Reference settling interval and its cycle count at the core clock
  localparam int CLK_PERIOD_NS   = 50;
  localparam int SETTLE_NS       = 10000;
  localparam int SETTLE_CYCLES   = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W    = 8;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

endpackage

// ===== logic/settle_timer.sv
// Reference settling timer: reports stable once the interval has run while enabled
`timescale 1ns/10ps
`default_nettype none
module settle_timer (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic enable,
  output var  logic stable
);

  localparam logic [lvd_pkg::SETTLE_CNT_W-1:0] LAST =
    lvd_pkg::SETTLE_CNT_W'(lvd_pkg::SETTLE_CYCLES - 1);

  logic [lvd_pkg::SETTLE_CNT_W-1:0] cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q  <= '0;
      stable <= 1'b0;
    end else if (!enable) begin
      // Dropping the enable restarts the whole interval
      cnt_q  <= '0;
      stable <= 1'b0;
    end else if (!stable) begin
      if (cnt_q == LAST) begin
        stable <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule // settle_timer
`default_nettype wire

// ===== verif/lvd_ctrl_tb.sv
// Self-checking bench for the detector control block
`timescale 1ns/10ps
`default_nettype none
module lvd_ctrl_tb;
  localparam logic [7:0] CTL = lvd_pkg::DETECTOR_CONTROL_OFS;
  localparam logic [7:0] GIC = lvd_pkg::CORE_INTERRUPT_CONTROL_OFS;
  localparam logic [7:0] FLG = lvd_pkg::PERIPHERAL_FLAGS_TWO_OFS;
  localparam logic [7:0] ENA = lvd_pkg::PERIPHERAL_ENABLES_TWO_OFS;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        trip;
  logic        sleep = 1'b0;
  logic        supply_low = 1'b0;
  logic        ext_low = 1'b0;
  logic        pwr;
  logic        ext_sel;
  logic [3:0]  level;
  logic        irq;
  logic        wake;
  logic [31:0] rq;
  logic        rerr;
  int          error_cnt = 0;
  int          num_checks = 0;

  always #25 clk = ~clk;

  lvd_ctrl u_lvd_ctrl (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .COMPARATOR_TRIP(trip), .SLEEP_ACTIVE(sleep),
    .DETECTOR_POWER_EN(pwr), .EXTERNAL_TRIP_SELECT(ext_sel), .TRIP_LEVEL(level),
    .IRQ(irq), .WAKE(wake));
  trip_model u_trip_model (.power_en(pwr), .ext_sel(ext_sel), .supply_low(supply_low),
    .ext_low(ext_low), .trip(trip));

  task automatic conclude();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Held request until pready is sampled high, then two idle edges
  // Registered outputs follow a write one edge late, so they are settled on return
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      error_cnt++;
      conclude();
    end
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rq, exp, what);
  endtask

  task automatic pulse_trip(input logic internal);
    if (internal) supply_low <= 1'b1;
    else ext_low <= 1'b1;
    repeat (2) @(posedge clk);
    supply_low <= 1'b0;
    ext_low <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic reset_values();
    rd(CTL, 32'h0000_0000, "control");
    rd(FLG, 32'h0000_0000, "flags");
    chk({31'h0000_0000, pwr}, 32'h0000_0000, "power");
    rd(8'h40, 32'h0000_0000, "unmapped");
    chk({31'h0000_0000, rerr}, 32'h0000_0001, "slverr");
  endtask

  task automatic level_select();
    apb(1'b1, CTL, 32'h0000_0005);
    chk({28'h0000_000, level}, 32'h0000_0005, "level");
    chk({31'h0000_0000, ext_sel}, 32'h0000_0000, "ext sel");
    apb(1'b1, CTL, 32'h0000_000F);
    chk({31'h0000_0000, ext_sel}, 32'h0000_0001, "ext sel");
  endtask

  task automatic settle_and_flag();
    apb(1'b1, CTL, 32'h0000_001F);
    chk({31'h0000_0000, pwr}, 32'h0000_0001, "power");
    apb(1'b1, FLG, 32'h0000_0004);
    apb(1'b1, ENA, 32'h0000_0004);
    apb(1'b1, GIC, 32'h0000_0080);
    ext_low <= 1'b1;
    repeat (20) @(posedge clk);
    ext_low <= 1'b0;
    rd(CTL, 32'h0000_001F, "stable early");
    rd(FLG, 32'h0000_0000, "flag settling");
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq settling");
    repeat (lvd_pkg::SETTLE_CYCLES) @(posedge clk);
    rd(CTL, 32'h0000_003F, "stable");
    pulse_trip(1'b0);
    chk({31'h0000_0000, irq}, 32'h0000_0001, "irq");
    rd(FLG, 32'h0000_0004, "flag");
    apb(1'b1, ENA, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq masked");
    apb(1'b1, ENA, 32'h0000_0004);
    apb(1'b1, FLG, 32'h0000_0004);
    rd(FLG, 32'h0000_0000, "flag cleared");
  endtask

  task automatic sleep_wake();
    sleep <= 1'b1;
    apb(1'b1, GIC, 32'h0000_0000);
    pulse_trip(1'b0);
    chk({31'h0000_0000, wake}, 32'h0000_0001, "wake");
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq global off");
    apb(1'b1, GIC, 32'h0000_0080);
    chk({31'h0000_0000, irq}, 32'h0000_0001, "irq global on");
    sleep <= 1'b0;
    apb(1'b1, FLG, 32'h0000_0004);
  endtask

  task automatic disable_and_reset();
    apb(1'b1, CTL, 32'h0000_0015);
    rd(CTL, 32'h0000_0035, "stable kept");
    pulse_trip(1'b0);
    rd(FLG, 32'h0000_0000, "ext input ignored");
    pulse_trip(1'b1);
    rd(FLG, 32'h0000_0004, "internal trip");
    apb(1'b1, FLG, 32'h0000_0004);
    apb(1'b1, CTL, 32'h0000_000F);
    rd(CTL, 32'h0000_000F, "stable off");
    pulse_trip(1'b0);
    rd(FLG, 32'h0000_0000, "flag disabled");
    apb(1'b1, CTL, 32'h0000_0015);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(CTL, 32'h0000_0000, "control after reset");
    chk({28'h0000_000, level}, 32'h0000_0000, "level after reset");
    chk({31'h0000_0000, pwr}, 32'h0000_0000, "power after reset");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    reset_values();
    level_select();
    settle_and_flag();
    sleep_wake();
    disable_and_reset();
    conclude();
  end
endmodule // lvd_ctrl_tb
`default_nettype wire

// ===== verif/trip_model.sv
// Behavioural supply comparator facing the detector control block
`timescale 1ns/10ps
`default_nettype none
module trip_model (
  input  wire logic power_en,
  input  wire logic ext_sel,
  input  wire logic supply_low,
  input  wire logic ext_low,
  output var  logic trip
);
  // Unpowered comparator never trips
  always_comb trip = power_en & (ext_sel ? ext_low : supply_low);
endmodule // trip_model
`default_nettype wire
